/* hdl/sadc_axil.sv */
// AXI4-Lite slave front end producing single-cycle register strobes.
`default_nettype none
module sadc_axil (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // AXI4-Lite
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // Register file side
  output sadc_pkg::sadc_reg_req_t req,
  input  wire logic [31:0]  rd_data,
  input  wire logic         rd_err
);
  import sadc_pkg::*;

  typedef struct packed {
    logic        aw_ok;
    logic [7:0]  awaddr;
    logic        w_ok;
    logic [31:0] wdata;
    logic        bvalid;
    logic        rpend;
    logic [7:0]  araddr;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sadc_bus_st_t;

  sadc_bus_st_t st_reg;
  sadc_bus_st_t st_next;

  // Address and data may arrive in either order; partial strobes are written whole.
  always_comb begin
    st_next = st_reg;
    req = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_ok = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_ok = 1'b1;
      st_next.wdata = s_axi_wdata;
    end
    if (st_reg.aw_ok && st_reg.w_ok && !st_reg.bvalid) begin
      req.wr = 1'b1;
      req.waddr = st_reg.awaddr;
      req.wdata = st_reg.wdata;
      st_next.aw_ok = 1'b0;
      st_next.w_ok = 1'b0;
      st_next.bvalid = 1'b1;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rpend = 1'b1;
      st_next.araddr = s_axi_araddr;
    end
    if (st_reg.rpend) begin
      req.rd = 1'b1;
      req.raddr = st_reg.araddr;
      st_next.rpend = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_data;
      st_next.rresp = rd_err ? 2'b10 : 2'b00;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = !st_reg.aw_ok && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_ok && !st_reg.bvalid;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = 2'b00;
  assign s_axi_arready = !st_reg.rpend && !st_reg.rvalid;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;
endmodule
`default_nettype wire

/* hdl/sadc_clkdiv.sv */
// Converter clock tick generator, limiting the converter rate.
`default_nettype none
`include "sadc_regs.svh"
module sadc_clkdiv #(
  parameter int DIV = (`SADC_SYS_MHZ + `SADC_FCONV_MHZ - 1) / `SADC_FCONV_MHZ
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Tick
  input  wire logic run,
  output logic      tick
);
  import sadc_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } sadc_div_st_t;

  sadc_div_st_t st_reg;
  sadc_div_st_t st_next;

  initial begin
    if (DIV < 1 || DIV > 255) $error("sadc_clkdiv: DIV out of range");
  end

  // Divide down so the converter clock never exceeds its limit.
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run) begin
      st_next.cnt = 8'h00;
    end else if (st_reg.cnt == 8'(DIV - 1)) begin
      st_next.cnt = 8'h00;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule
`default_nettype wire

/* hdl/sadc_pkg.sv */
// Types shared by the sequencer modules.
`default_nettype none
package sadc_pkg;
  typedef enum logic [1:0] {
    SADC_IDLE   = 2'b00,
    SADC_SAMPLE = 2'b01,
    SADC_CONV   = 2'b10
  } sadc_state_t;

  // Request to the analog core.
  typedef struct packed {
    logic [3:0] mux_sel;
    logic [1:0] ref_sel;
    logic       sample;
    logic       convert;
    logic       tick;
  } sadc_ana_t;

  // Bus write and read strobes passed to the register file.
  typedef struct packed {
    logic        wr;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic        rd;
    logic [7:0]  raddr;
  } sadc_reg_req_t;
endpackage
`default_nettype wire

/* hdl/sadc_regs.svh */
// Register offsets, field positions, reset values and timing constants of the sequencer.
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

// Register byte offsets.
`define SADC_CTRL_OFS      8'h00
`define SADC_CHEN_OFS      8'h04
`define SADC_LIMLO_OFS     8'h08
`define SADC_LIMHI_OFS     8'h0c
`define SADC_STAT_OFS      8'h10
`define SADC_MASK_OFS      8'h14
`define SADC_SAMP_OFS      8'h20
`define SADC_RES_OFS       8'h40

// Control register fields.
`define SADC_CTRL_EN       0
`define SADC_CTRL_AUTO     1
`define SADC_CTRL_START    2
`define SADC_CTRL_CONT     3
`define SADC_CTRL_REF_LO   4
`define SADC_CTRL_MSEL_LO  8
`define SADC_CTRL_TEMP     12
`define SADC_CTRL_LP       13

// Status bits.
`define SADC_ST_RANGE      0
`define SADC_ST_SCAN       1
`define SADC_ST_BUSY       8

// Timing: converter clock limit and cycles per conversion.
`define SADC_FCONV_MHZ     18
`define SADC_CONV_CLKS     18
`define SADC_SYS_MHZ       200
`define SADC_SAMP_RST      8'h04

`endif

/* hdl/sadc_top.sv */
// Channel sequencer, limit checker and register file of the SAR converter.
// Notes on behaviour
// - Results are twelve bits; aggregate rate targets one million samples per second.
// - Each conversion takes at least eighteen converter clocks at eighteen megahertz maximum.
// - Eight fixed input channels, each enabled for scans by its own bit.
// - A started scan walks all enabled channels with no software help.
// - Next channel is sampled right after conversion; no idle slots inserted.
// - Channel choice comes from the sequencer or from a software mux setting.
// - Each channel keeps its own result register readable after the scan.
// - Sample time is programmed separately per channel.
// - Programmable low and high limits define the acceptable result range.
// - Out-of-range result raises its interrupt flag at once, mid-scan.
// - Reference select: supply, half supply, bandgap, or external pin.
// - Sample-and-hold window length is programmable for slow drivers.
// - Converter and sequencer halt while deep low-power mode is signalled.
// - Temperature sensor may be chosen as a conversion input.
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`default_nettype none
`include "sadc_regs.svh"
module sadc_top #(
  parameter int NCH   = 8,
  parameter int RES_W = 12
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // AXI4-Lite
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // Power mode
  input  wire logic         deep_lp_mode,
  // Analog core
  output sadc_pkg::sadc_ana_t ana,
  input  wire logic         conv_done,
  input  wire logic [11:0]  conv_result,
  // Interrupt
  output logic              irq
);
  import sadc_pkg::*;

  // ============================================================
  // Constants and state
  // Select code that routes the on-chip temperature sensor to the converter.
  localparam logic [3:0] TEMP_SEL = 4'h8;

  typedef struct packed {
    sadc_state_t state;
    logic [31:0] ctrl;
    logic [7:0]  chen;
    logic [11:0] lim_lo;
    logic [11:0] lim_hi;
    logic [1:0]  stat;
    logic [1:0]  mask;
    logic [2:0]  ch;
    logic [7:0]  samp_cnt;
    logic [7:0]  conv_cnt;
    logic        scanning;
    logic [NCH-1:0][7:0]       samp;
    logic [NCH-1:0][RES_W-1:0] res;
  } sadc_st_t;

  sadc_st_t      st_reg;
  sadc_st_t      st_next;
  sadc_reg_req_t req;
  logic [31:0]   rd_data;
  logic          rd_err;
  logic          tick;
  logic          run;

  initial begin
    if (NCH != 8 || RES_W != 12) $error("sadc_top: only 8 channels of 12 bits");
  end

  // ============================================================
  // Channel helpers
  // Next enabled channel above cur, wrapping to the lowest enabled one.
  function automatic logic [2:0] next_ch(input logic [7:0] en, input logic [2:0] cur);
    logic [2:0] c;
    logic [2:0] r;
    r = cur;
    for (int i = 7; i >= 1; i--) begin
      c = cur + 3'(i);
      if (en[c]) r = c;
    end
    return r;
  endfunction

  // Lowest enabled channel.
  function automatic logic [2:0] first_ch(input logic [7:0] en);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (en[i]) r = 3'(i);
    end
    return r;
  endfunction

  // ============================================================
  // Submodules
  // Bus front end.
  sadc_axil u_bus (
    .mclk          (mclk),
    .sys_rst       (sys_rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .req           (req),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // Converter clock; it stops entirely in deep low-power mode.
  assign run = st_reg.ctrl[`SADC_CTRL_EN] && !deep_lp_mode;

  sadc_clkdiv u_div (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .run     (run),
    .tick    (tick)
  );

  // ============================================================
  // Register file
  // Register read mux; results and sample times sit in windows of eight words.
  // Unmapped addresses answer zero data with an error response, so a stray read is visible.
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (req.raddr >= `SADC_SAMP_OFS && req.raddr < `SADC_SAMP_OFS + 8'h20) begin
      rd_data = {24'h000000, st_reg.samp[req.raddr[4:2]]};
    end else if (req.raddr >= `SADC_RES_OFS && req.raddr < `SADC_RES_OFS + 8'h20) begin
      rd_data = {20'h00000, st_reg.res[req.raddr[4:2]]};
    end else begin
      case (req.raddr)
        `SADC_CTRL_OFS:  rd_data = st_reg.ctrl;
        `SADC_CHEN_OFS:  rd_data = {24'h000000, st_reg.chen};
        `SADC_LIMLO_OFS: rd_data = {20'h00000, st_reg.lim_lo};
        `SADC_LIMHI_OFS: rd_data = {20'h00000, st_reg.lim_hi};
        `SADC_STAT_OFS:  rd_data = {23'h000000, st_reg.state != SADC_IDLE, 6'h00, st_reg.stat};
        `SADC_MASK_OFS:  rd_data = {30'h00000000, st_reg.mask};
        default:         rd_err = 1'b1;
      endcase
    end
  end

  // ============================================================
  // Sequencer
  // Register writes and the sequencing state machine.
  always_comb begin
    logic [1:0] set_st;
    logic       start;
    logic [2:0] nxt;
    logic       live;
    set_st = 2'b00;
    start = 1'b0;
    nxt = 3'h0;
    live = 1'b0;
    st_next = st_reg;
    st_next.ctrl[`SADC_CTRL_START] = 1'b0;
    if (req.wr) begin
      if (req.waddr >= `SADC_SAMP_OFS && req.waddr < `SADC_SAMP_OFS + 8'h20) begin
        st_next.samp[req.waddr[4:2]] = req.wdata[7:0];
      end else begin
        case (req.waddr)
          `SADC_CTRL_OFS: begin
            st_next.ctrl = {18'h00000, req.wdata[13:0]};
            start = req.wdata[`SADC_CTRL_START];
          end
          `SADC_CHEN_OFS:  st_next.chen = req.wdata[7:0];
          `SADC_LIMLO_OFS: st_next.lim_lo = req.wdata[11:0];
          `SADC_LIMHI_OFS: st_next.lim_hi = req.wdata[11:0];
          `SADC_MASK_OFS:  st_next.mask = req.wdata[1:0];
          default: ;
        endcase
      end
    end
    // Enable and mode come from this cycle's write, so one write can enable and start.
    live = st_next.ctrl[`SADC_CTRL_EN] && !deep_lp_mode;
    case (st_reg.state)
      SADC_IDLE: begin
        if (start && live) begin
          st_next.scanning = 1'b1;
          st_next.ch = st_next.ctrl[`SADC_CTRL_AUTO] ? first_ch(st_next.chen)
                                                     : st_next.ctrl[`SADC_CTRL_MSEL_LO +: 3];
          st_next.samp_cnt = st_reg.samp[st_next.ch];
          st_next.state = SADC_SAMPLE;
        end
      end
      SADC_SAMPLE: begin
        // A programmed time of zero still gives one tick of sampling.
        if (tick) begin
          if (st_reg.samp_cnt <= 8'h01) begin
            st_next.conv_cnt = 8'(`SADC_CONV_CLKS);
            st_next.state = SADC_CONV;
          end else begin
            st_next.samp_cnt = st_reg.samp_cnt - 8'h01;
          end
        end
      end
      SADC_CONV: begin
        if (tick && st_reg.conv_cnt != 8'h00) begin
          st_next.conv_cnt = st_reg.conv_cnt - 8'h01;
        end
        // An answer before the full count has run out is ignored.
        if (st_reg.conv_cnt == 8'h00 && conv_done) begin
          st_next.res[st_reg.ch] = conv_result;
          if (conv_result < st_reg.lim_lo || conv_result > st_reg.lim_hi) begin
            set_st[`SADC_ST_RANGE] = 1'b1;
          end
          nxt = next_ch(st_reg.chen, st_reg.ch);
          if (st_reg.ctrl[`SADC_CTRL_AUTO] && nxt > st_reg.ch) begin
            st_next.ch = nxt;
            st_next.samp_cnt = st_reg.samp[nxt];
            st_next.state = SADC_SAMPLE;
          end else begin
            set_st[`SADC_ST_SCAN] = 1'b1;
            if (st_reg.ctrl[`SADC_CTRL_CONT]) begin
              st_next.ch = st_reg.ctrl[`SADC_CTRL_AUTO] ? nxt
                                                        : st_reg.ctrl[`SADC_CTRL_MSEL_LO +: 3];
              st_next.samp_cnt = st_reg.samp[st_next.ch];
              st_next.state = SADC_SAMPLE;
            end else begin
              st_next.scanning = 1'b0;
              st_next.state = SADC_IDLE;
            end
          end
        end
      end
      default: st_next.state = SADC_IDLE;
    endcase
    // Disabling or entering low power aborts any scan in flight.
    if (!live) begin
      st_next.state = SADC_IDLE;
      st_next.scanning = 1'b0;
    end
    // Write one to clear; a new event in the same cycle wins.
    if (req.wr && req.waddr == `SADC_STAT_OFS) begin
      st_next.stat = st_reg.stat & ~req.wdata[1:0];
    end
    st_next.stat = st_next.stat | set_st;
  end

  // ============================================================
  // State register
  // Limits open fully and sample times start non-zero, so a scan right after
  // reset raises no range flag and never sees an empty sample window.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.lim_hi <= 12'hfff;
      st_reg.samp <= {NCH{`SADC_SAMP_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  // ============================================================
  // Analog core and interrupt
  // Analog core drive; the temperature sensor overrides the pin channel.
  always_comb begin
    ana.mux_sel = st_reg.ctrl[`SADC_CTRL_TEMP] ? TEMP_SEL : {1'b0, st_reg.ch};
    ana.ref_sel = st_reg.ctrl[`SADC_CTRL_REF_LO +: 2];
    ana.sample = st_reg.state == SADC_SAMPLE;
    ana.convert = st_reg.state == SADC_CONV;
    ana.tick = tick;
  end

  // Level interrupt: high while any unmasked status flag is set.
  assign irq = |(st_reg.stat & st_reg.mask);
endmodule
`default_nettype wire

/* test/sadc_core_model.sv */
// Behavioural model of the analog converter core behind the sequencer.
`default_nettype none
module sadc_core_model
  import sadc_pkg::*;
(
  // Clock
  input wire logic                mclk,
  // Requests and scenario controls
  input wire sadc_pkg::sadc_ana_t ana,
  input wire logic                early,
  input wire logic                slow,
  // Answer
  output logic                    conv_done,
  output logic [11:0]             conv_result
);
  timeunit 1ns;
  timeprecision 1ps;
  int ticks;
  initial begin
    ticks = 0;
    conv_done = 1'b0;
    conv_result = 12'h000;
  end
  // ======
  // Conversion timing
  // Answers after the 18th tick, or two ticks later when slow. Between answers the result
  // toggles every cycle, so a stale value never passes for a fresh one.
  always @(posedge mclk) begin
    conv_done <= 1'b0;
    conv_result <= ~conv_result;
    if (!ana.convert) ticks <= 0;
    else if (ana.tick) begin
      ticks <= ticks + 1;
      if (early && ticks == 4) begin
        conv_done <= 1'b1;
        conv_result <= 12'hbad;
      end
      if (ticks == (slow ? 19 : 17)) begin
        conv_done <= 1'b1;
        conv_result <= {ana.mux_sel, 8'h35};
      end
    end
  end
endmodule
`default_nettype wire

/* test/sadc_top_sva.sv */
// Port checker of the converter sequencer, bound into its top module.
`default_nettype none
module sadc_top_sva
  import sadc_pkg::*;
(
  // Clock and reset
  input wire logic                mclk,
  input wire logic                sys_rst,
  // Read address and data
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  // Converter side
  input wire logic                deep_lp_mode,
  input wire sadc_pkg::sadc_ana_t ana,
  input wire logic                conv_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // Helper logic
  // Ticks seen in this convert phase; it saturates so a stuck phase cannot wrap round.
  logic [4:0] conv_ticks_reg;
  always_ff @(posedge mclk) begin
    if (sys_rst || !ana.convert) conv_ticks_reg <= 5'h00;
    else if (ana.tick && conv_ticks_reg != 5'h1f) conv_ticks_reg <= conv_ticks_reg + 5'h01;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // ======
  // Assertions
  phase_excl_a:
    assert property (!(ana.sample && ana.convert)) else $error("sample and convert overlap");
  tick_rate_a:
    assert property (ana.tick |=> !ana.tick [*8]) else $error("converter tick too fast");
  early_done_a:
    assert property (ana.convert && conv_done && conv_ticks_reg < 5'h12 && !deep_lp_mode
      |=> ana.convert) else $error("conversion ended before its full count");
  next_slot_a:
    assert property (ana.convert && conv_done && conv_ticks_reg >= 5'h12 |=> !ana.convert)
      else $error("accepted result did not end the convert phase");
  mux_range_a:
    assert property (ana.mux_sel <= 4'h8) else $error("input select out of range");
  mux_hold_a:
    assert property (ana.convert ##1 ana.convert |-> $stable(ana.mux_sel))
      else $error("input select moved during conversion");
  lp_halt_a:
    assert property (deep_lp_mode ##1 deep_lp_mode |-> !ana.sample && !ana.convert)
      else $error("converter active in low power");
  read_lat_a:
    assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
      else $error("read answer late");
endmodule
bind sadc_top sadc_top_sva chk_u (.mclk(mclk), .sys_rst(sys_rst),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .deep_lp_mode(deep_lp_mode), .ana(ana),
  .conv_done(conv_done));
`default_nettype wire

/* test/sadc_top_tb.sv */
// Self-checking bench of the converter sequencer and its register file.
`default_nettype none
`include "sadc_regs.svh"
module sadc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sadc_pkg::*;
  logic        mclk, sys_rst, awv, wv, bready, arv, rready, deep_lp_mode, early, slow;
  logic        awready, wready, bvalid, arready, rvalid, conv_done, irq;
  logic [7:0]  aw, ar;
  logic [31:0] wd, rdata;
  logic [1:0]  bresp, rresp;
  logic [11:0] conv_result;
  sadc_ana_t   ana;
  logic [5:0]  start_q[$];
  int          errors, num_checks, samp_len, samp_cnt;
  sadc_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .deep_lp_mode(deep_lp_mode), .ana(ana), .conv_done(conv_done),
    .conv_result(conv_result), .irq(irq));
  sadc_core_model core_u (.mclk(mclk), .ana(ana), .early(early), .slow(slow),
    .conv_done(conv_done), .conv_result(conv_result));
  always #2.5 mclk = ~mclk;
  // Logs channel and reference at each sample start; negedge keeps clear of the edge.
  always @(negedge mclk) begin
    if (ana.sample && samp_cnt == 0) start_q.push_back({ana.ref_sel, ana.mux_sel});
    if (ana.sample) samp_cnt++;
    else if (samp_cnt != 0) begin
      samp_len = samp_cnt;
      samp_cnt = 0;
    end
  end
  // ======
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One clock; a hang is cut short here and counted as a mismatch.
  task automatic step(inout int n);
    @(posedge mclk);
    n++;
    if (n > 20000) begin
      check(32'(n), 32'h0);
      stop_test();
    end
  endtask
  // Ready and valid are looked at on the negedge, so they equal what the next edge takes.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [2:0] hs;
    logic [1:0] br;
    int         n;
    n = 0;
    br = 2'h3;
    hs = 3'h0;
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    while (!hs[2]) begin
      @(negedge mclk);
      hs |= {bvalid, wready, awready};
      if (bvalid) br = bresp;
      step(n);
      if (hs[0]) awv <= 1'b0;
      if (hs[1]) wv <= 1'b0;
      if (hs[2]) bready <= 1'b0;
    end
    step(n);
    check({30'h0, br}, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic [1:0] hs;
    int         n;
    n = 0;
    hs = 2'h0;
    ar <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    while (!hs[1]) begin
      @(negedge mclk);
      d = rdata;
      r = rresp;
      hs |= {rvalid, arready};
      step(n);
      if (hs[0]) arv <= 1'b0;
      if (hs[1]) rready <= 1'b0;
    end
    step(n);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, e);
    check({30'h0, r}, {30'h0, er});
  endtask
  // Polls a status bit with a bounded number of reads.
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    logic [31:0] d;
    logic [1:0]  r;
    d = {32{~v}};
    for (int i = 0; i < 600 && d[b] !== v; i++) rd(a, d, r);
    if (d[b] !== v) begin
      check({31'h0, d[b]}, {31'h0, v});
      stop_test();
    end
  endtask
  // ======
  // Scenarios
  task automatic t_reset();
    rchk(`SADC_CTRL_OFS, 32'h0);
    rchk(`SADC_LIMHI_OFS, 32'hfff);
    rchk(`SADC_SAMP_OFS, 32'h4);
    rchk(8'h5c, 32'h0);
    rchk(`SADC_STAT_OFS, 32'h0);
    rchk(8'h60, 32'h0, 2'h2);
  endtask
  // Early answers from the core are offered throughout and must be ignored.
  task automatic t_scan();
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    early <= 1'b1;
    wr(`SADC_CHEN_OFS, 32'h25);
    wr(`SADC_LIMLO_OFS, 32'h100);
    wr(`SADC_LIMHI_OFS, 32'h400);
    wr(`SADC_MASK_OFS, 32'h3);
    start_q.delete();
    wr(`SADC_CTRL_OFS, 32'h7);
    n = 0;
    while (irq !== 1'b1) step(n);
    rd(`SADC_STAT_OFS, d, r);
    check({31'h0, d[1]}, 32'h0);
    poll(`SADC_STAT_OFS, 1, 1'b1);
    rchk(`SADC_STAT_OFS, 32'h3);
    check(32'(start_q.size()), 32'h3);
    check({26'h0, start_q[0]}, 32'h0);
    check({26'h0, start_q[1]}, 32'h2);
    check({26'h0, start_q[2]}, 32'h5);
    rchk(8'h40, 32'h035);
    rchk(8'h48, 32'h235);
    rchk(8'h54, 32'h535);
    wr(`SADC_STAT_OFS, 32'h3);
    rchk(`SADC_STAT_OFS, 32'h0);
    check({31'h0, irq}, 32'h0);
    early <= 1'b0;
  endtask
  // Manual conversions alternating channel 6 and the temperature sensor, with every reference and a rising sample time.
  task automatic t_manual();
    slow <= 1'b1;
    wr(`SADC_MASK_OFS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(8'h38, 32'(i + 1));
      start_q.delete();
      wr(`SADC_CTRL_OFS, 32'h605 | 32'(i) << 4 | 32'(i % 2) << 12);
      poll(`SADC_STAT_OFS, 0, 1'b1);
      poll(`SADC_STAT_OFS, 8, 1'b0);
      check({26'h0, start_q[0]}, {26'h0, 2'(i), i % 2 ? 4'h8 : 4'h6});
      check(32'(samp_len > 12 * i && samp_len <= 12 * i + 13), 32'h1);
      rchk(8'h58, {20'h0, i % 2 ? 4'h8 : 4'h6, 8'h35});
      check({31'h0, irq}, 32'h0);
      wr(`SADC_STAT_OFS, 32'h3);
    end
    slow <= 1'b0;
  endtask
  task automatic t_lowpower();
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    wr(`SADC_CHEN_OFS, 32'h82);
    start_q.delete();
    wr(`SADC_CTRL_OFS, 32'hf);
    n = 0;
    while (start_q.size() < 3) step(n);
    deep_lp_mode <= 1'b1;
    check({26'h0, start_q[0]}, 32'h1);
    check({26'h0, start_q[1]}, 32'h7);
    check({26'h0, start_q[2]}, 32'h1);
    rd(`SADC_STAT_OFS, d, r);
    check({31'h0, d[8]}, 32'h0);
    deep_lp_mode <= 1'b0;
    wr(`SADC_CTRL_OFS, 32'h0);
  endtask
  // ======
  // Main sequence
  initial begin
    {mclk, awv, wv, bready, arv, rready, deep_lp_mode, early, slow} = 9'h000;
    {aw, ar, wd} = 48'h0;
    sys_rst = 1'b1;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_scan();
    t_manual();
    t_lowpower();
    stop_test();
  end
endmodule
`default_nettype wire
